/* File: rtl/gpib_service_request_reporter.sv */
// Service request, serial poll status and event query logic of the instrument
`timescale 1ns/1ps
`include "srq_reporter_map.svh"
module gpib_service_request_reporter (
    input wire logic clock, // System clock, 40 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic cmd_error_valid, // Message could not be parsed
    input wire logic [9:0] cmd_error_code, // Code for the command error
    input wire logic exec_error_valid, // Message could not be executed
    input wire logic [9:0] exec_error_code, // Code for the execution error
    input wire logic sweep_done, // Sweep measurement finished
    input wire logic plot_done, // Plotter output finished
    input wire logic breaker_changed, // Circuit breaker state changed
    input wire logic interlock_changed, // Interlock state changed
    input wire logic general_request_enable_write, // Load general enable
    input wire logic completion_request_enable_write, // Load completion enable
    input wire logic enable_value, // Value for either enable write
    input wire logic general_request_enable_query, // Ask general enable
    input wire logic completion_request_enable_query, // Ask completion enable
    output logic enable_reply, // On or off answer
    output logic enable_reply_valid, // Enable answer strobe
    input wire logic poll_req, // Serial poll by the controller
    output logic poll_ack, // Poll answer strobe
    output logic [7:0] status_byte, // Poll answer
    input wire logic event_query, // Event query by the controller
    output logic event_ack, // Event answer strobe
    output logic [9:0] event_code_out, // Event answer
    output logic srq // Service request line, high asserts
);
    // Report may be asserted under the enables
    function automatic logic srq_allowed(srq_reporter_pkg::report_t r, logic gen, logic completion_request_enable);
        return r.valid && (r.completion_request_enable ? completion_request_enable : gen);
    endfunction : srq_allowed

    srq_reporter_pkg::report_t pending_reg, pending_next; // Report the next poll returns
    srq_reporter_pkg::report_t latest_reg, latest_next; // Most recent newer report
    srq_reporter_pkg::report_t new_report; // Report of this cycle's event
    logic power_on_reg; // Power-on event still to post
    logic gen_en_reg; // General request enable
    logic opc_en_reg; // Completion request enable
    logic poll_ack_reg, event_ack_reg, enable_valid_reg, enable_reply_reg;
    logic [7:0] status_reg; // Poll answer
    logic [9:0] code_reg; // Event answer
    wire logic comp_any; // Any completion event
    wire logic new_valid; // An event arrives this cycle
    wire logic [9:0] comp_code; // Code of the completion event
    wire logic [9:0] new_code; // Code of the arriving event
    wire srq_reporter_pkg::status_t new_status; // Category byte of the arriving event
    wire logic new_opc; // Arriving event is a completion
    wire logic serve; // Poll taken while requesting
    event_stack_if stk (); // Event code store port

    // Event selection, power-on first then errors then completions
    assign comp_any = sweep_done | plot_done | breaker_changed | interlock_changed;
    assign new_valid = power_on_reg | cmd_error_valid | exec_error_valid | comp_any;
    assign comp_code = sweep_done ? `CODE_SWEEP_DONE :
                       plot_done ? `CODE_PLOT_DONE :
                       breaker_changed ? `CODE_SUPPLY_RECOVERED : `CODE_INTERLOCK_CHANGED;
    assign new_code = power_on_reg ? `CODE_POWER_ON :
                      cmd_error_valid ? cmd_error_code :
                      exec_error_valid ? exec_error_code : comp_code;
    assign new_status = power_on_reg ? `STB_POWER_ON :
                        cmd_error_valid ? `STB_CMD_ERROR :
                        exec_error_valid ? `STB_EXEC_ERROR : `STB_DEVICE_EVENT;
    // completion events form their own request type
    assign new_opc = !(power_on_reg | cmd_error_valid | exec_error_valid);
    // One driver for the whole report
    assign new_report = '{valid: new_valid, completion_request_enable: new_opc, status: new_status};

    // line follows the pending report and its enable
    assign srq = srq_allowed(pending_reg, gen_en_reg, opc_en_reg);
    assign serve = poll_req && srq;

    // codes stored unless a query comes in the same cycle; that query takes the new code directly
    assign stk.push = new_valid && !event_query;
    assign stk.push_code = new_code;
    assign stk.pop = event_query && !new_valid;

    // Two-report status store
    always_comb begin
        pending_next = pending_reg;
        latest_next = latest_reg;
        if (serve) begin
            pending_next = latest_reg.valid ? latest_reg : new_report;
            latest_next = latest_reg.valid ? new_report : '0;
        end else if (new_valid) begin
            if (!pending_reg.valid) begin
                pending_next = new_report;
            end else begin
                latest_next = new_report;
            end
        end
    end

    // Report registers and power-on event
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg <= '0;
            latest_reg <= '0;
            power_on_reg <= 1'b1;
        end else begin
            pending_reg <= pending_next;
            latest_reg <= latest_next;
            power_on_reg <= 1'b0;
        end
    end

    // Enables, loaded by their commands
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gen_en_reg <= `GEN_ENABLE_RESET;
            opc_en_reg <= `OPC_ENABLE_RESET;
        end else begin
            if (general_request_enable_write) gen_en_reg <= enable_value;
            if (completion_request_enable_write) opc_en_reg <= enable_value;
        end
    end

    // Answers to poll, event query and enable queries
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            poll_ack_reg <= 1'b0;
            status_reg <= `STB_NONE;
            event_ack_reg <= 1'b0;
            code_reg <= `CODE_NONE;
            enable_valid_reg <= 1'b0;
            enable_reply_reg <= 1'b0;
        end else begin
            poll_ack_reg <= poll_req;
            if (poll_req) status_reg <= serve ? pending_reg.status : `STB_NONE;
            event_ack_reg <= event_query;
            if (event_query) code_reg <= new_valid ? new_code : stk.top_code;
            enable_valid_reg <= general_request_enable_query | completion_request_enable_query;
            if (general_request_enable_query) enable_reply_reg <= gen_en_reg;
            else if (completion_request_enable_query) enable_reply_reg <= opc_en_reg;
        end
    end

    assign poll_ack = poll_ack_reg;
    assign status_byte = status_reg;
    assign event_ack = event_ack_reg;
    assign event_code_out = code_reg;
    assign enable_reply_valid = enable_valid_reg;
    assign enable_reply = enable_reply_reg;

    // Event code store
    event_lifo #(.DEPTH(`LIFO_DEPTH)) u_lifo (
        .clock(clock),
        .rst_n(rst_n),
        .stk(stk)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    srq_raise_a: assert property (
        pending_reg.valid && !pending_reg.completion_request_enable && gen_en_reg |-> srq)
        else $error("General report held but line not asserted");
    poll_status_a: assert property (
        serve |=> poll_ack && status_byte == $past(pending_reg.status))
        else $error("Poll answer is not the pending status byte");
    srq_release_a: assert property (
        serve && !latest_reg.valid && !new_valid |=> !srq ##1 (!srq || $past(new_valid)))
        else $error("Request not released after the poll");
    srq_repeat_a: assert property (
        serve && srq_allowed(latest_reg, gen_en_reg, opc_en_reg) |=> srq)
        else $error("Request not reasserted for remaining report");
    keep_two_a: assert property (
        pending_reg.valid && new_valid && !serve
        |=> pending_reg == $past(pending_reg) && latest_reg.status == $past(new_report.status))
        else $error("Pending or latest status not kept");
    mask_opc_a: assert property (
        pending_reg.completion_request_enable && !opc_en_reg |-> !srq)
        else $error("Masked completion request asserted");
    query_code_a: assert property (
        event_query && !new_valid |=> event_ack && event_code_out == $past(stk.top_code))
        else $error("Event answer is not the newest code");
    empty_zero_a: assert property (
        event_query && !new_valid && stk.empty |=> event_code_out == 10'h000)
        else $error("Empty store answered nonzero");
    enable_reply_a: assert property (
        general_request_enable_query |=> enable_reply_valid && enable_reply == $past(gen_en_reg))
        else $error("General enable answer wrong");
    cmd_status_a: assert property (
        cmd_error_valid && !power_on_reg && !pending_reg.valid |=> pending_reg.status == 8'h61)
        else $error("Command error did not report 97");
    power_on_a: assert property (
        power_on_reg && !pending_reg.valid |=> pending_reg.status == 8'h41 && !power_on_reg)
        else $error("Power-on status not reported");
    comp_type_a: assert property (
        sweep_done && !power_on_reg && !cmd_error_valid && !exec_error_valid
        && !pending_reg.valid |=> pending_reg.completion_request_enable && pending_reg.status == 8'hc0)
        else $error("Completion not reported as its own type");

    cover_poll_c: cover property (serve ##[1:20] serve);
    cover_query_c: cover property (event_query && !stk.empty);
    cover_masked_c: cover property (pending_reg.valid && !srq ##1 srq);
endmodule : gpib_service_request_reporter

/* File: inc/srq_reporter_map.svh */
// Constants for the service request reporter: status bytes, event codes, depths, resets
`ifndef SRQ_REPORTER_MAP_SVH
`define SRQ_REPORTER_MAP_SVH
// Status bytes returned by a serial poll (decimal 0, 65, 97, 98, 192)
`define STB_NONE 8'h00
`define STB_POWER_ON 8'h41
`define STB_CMD_ERROR 8'h61
`define STB_EXEC_ERROR 8'h62
`define STB_DEVICE_EVENT 8'hc0
// Event codes returned by an event query (decimal 0, 401, 752..755)
`define CODE_NONE 10'h000
`define CODE_POWER_ON 10'h191
`define CODE_SWEEP_DONE 10'h2f0
`define CODE_PLOT_DONE 10'h2f1
`define CODE_SUPPLY_RECOVERED 10'h2f2
`define CODE_INTERLOCK_CHANGED 10'h2f3
// Event code store depth
`define LIFO_DEPTH 10
// Request enables after reset
`define GEN_ENABLE_RESET 1'b1
`define OPC_ENABLE_RESET 1'b0
`endif

/* File: inc/srq_reporter_pkg.sv */
// Types shared by the service request reporter and its event code store
package srq_reporter_pkg;
    typedef logic [7:0] status_t; // Serial poll status byte
    typedef logic [9:0] code_t; // Event code, unsigned
    // One saved status report
    typedef struct packed {
        logic valid; // Report waiting
        logic completion_request_enable; // Operation complete type
        status_t status; // Status byte
    } report_t;
endpackage : srq_reporter_pkg

/* File: inc/event_stack_if.sv */
// Connection between the reporter and its event code store
`timescale 1ns/1ps
interface event_stack_if;
    logic push; // Store a new code
    srq_reporter_pkg::code_t push_code; // Code to store
    logic pop; // Remove newest code
    srq_reporter_pkg::code_t top_code; // Newest code, zero when empty
    logic empty; // Nothing stored
    logic full; // All entries used
    modport owner (output push, push_code, pop, input top_code, empty, full);
    modport stack (input push, push_code, pop, output top_code, empty, full);
endinterface : event_stack_if

/* File: rtl/event_lifo.sv */
// Last-in-first-out store of event codes that drops the oldest when full
`timescale 1ns/1ps
`include "srq_reporter_map.svh"
module event_lifo #(
    parameter int DEPTH = `LIFO_DEPTH
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    event_stack_if.stack stk // Push and pop port
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // Depth check at elaboration
    if (DEPTH < 2) begin : g_depth_check
        $error("event_lifo needs a depth of at least two");
    end

    srq_reporter_pkg::code_t mem_reg [DEPTH]; // Entry 0 is the oldest
    logic [CW-1:0] count_reg; // Codes held
    logic [CW-1:0] top_idx; // Index of newest code

    assign top_idx = count_reg - 1'b1;
    assign stk.full = (count_reg == DEPTH_C);
    assign stk.empty = (count_reg == '0);
    assign stk.top_code = stk.empty ? `CODE_NONE : mem_reg[top_idx];

    // Storage; when full everything slides down one place
    always_ff @(posedge clock) begin
        if (stk.push) begin
            if (stk.full) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    mem_reg[i] <= mem_reg[i+1];
                end
                mem_reg[DEPTH-1] <= stk.push_code;
            end else begin
                mem_reg[count_reg] <= stk.push_code;
            end
        end
    end

    // Fill level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (stk.push && !stk.full) begin
            count_reg <= count_reg + 1'b1;
        end else if (!stk.push && stk.pop && !stk.empty) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    overflow_keep_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        stk.push && stk.full |=> stk.full && stk.top_code == $past(stk.push_code))
        else $error("Push into full store lost the new code");
    push_top_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        stk.push |=> stk.top_code == $past(stk.push_code) && !stk.empty)
        else $error("Pushed code is not on top");
    cover_full_c: cover property (@(posedge clock) disable iff (!rst_n) stk.push && stk.full);
endmodule : event_lifo

/* File: tb/gpib_controller_model.sv */
// Bus controller model issuing serial polls and event queries
`timescale 1ns/1ps
module gpib_controller_model (
    input wire logic clock, // System clock
    input wire logic poll_ack, // Poll answer strobe
    input wire logic [7:0] status_byte, // Poll answer
    input wire logic event_ack, // Event answer strobe
    input wire logic [9:0] event_code_out, // Event answer
    output logic poll_req, // Serial poll
    output logic event_query // Event query
);
    // Idle at time zero
    initial begin
        poll_req = 1'b0;
        event_query = 1'b0;
    end
    // One poll pulse, answer taken at the strobe edge
    task poll(output srq_reporter_pkg::status_t s);
        s = 8'hff;
        @(posedge clock) poll_req <= 1'b1;
        @(posedge clock) poll_req <= 1'b0;
        repeat (4) begin
            @(posedge clock);
            if (poll_ack === 1'b1) begin
                s = status_byte;
                break;
            end
        end
    endtask : poll
    // One event query pulse, code taken at the strobe edge
    task query(output srq_reporter_pkg::code_t c);
        c = 10'h3ff;
        @(posedge clock) event_query <= 1'b1;
        @(posedge clock) event_query <= 1'b0;
        repeat (4) begin
            @(posedge clock);
            if (event_ack === 1'b1) begin
                c = event_code_out;
                break;
            end
        end
    endtask : query
    task service(output srq_reporter_pkg::status_t s, output srq_reporter_pkg::code_t c);
        poll(s);
        query(c);
    endtask : service
endmodule : gpib_controller_model

/* File: tb/test_gpib_service_request_reporter.sv */
// Self-checking bench with a queue model of the reporter
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_gpib_service_request_reporter;
    logic clock = 1'b0; // 40 MHz clock
    logic rst_n = 1'b0; // Reset, active low
    logic [5:0] ev = 6'h00; // Event pulses
    logic [9:0] ecode = 10'h000; // Error code
    logic [1:0] wr = 2'b00; // Enable writes
    logic [1:0] qry = 2'b00; // Enable queries
    logic enable_value = 1'b0; // Write value
    logic enable_reply, enable_reply_valid, poll_ack, event_ack, srq, poll_req, event_query;
    logic [7:0] status_byte; // Poll answer
    logic [9:0] event_code_out; // Event answer
    int mismatches = 0, checks_done = 0, cyc = 0;
    bit [31:0] seed = 32'h9cc58da0; // Xorshift state
    int pv = 0, ps = 0, po = 0, lv = 0, ls = 0, lo = 0, gen = 1, completion_request_enable = 0; // Model
    int codes[$]; // Model code store, newest first
    srq_reporter_pkg::status_t s;
    srq_reporter_pkg::code_t c;
    gpib_service_request_reporter u_gpib_service_request_reporter (.clock(clock),
        .rst_n(rst_n), .cmd_error_valid(ev[0]), .cmd_error_code(ecode),
        .exec_error_valid(ev[1]), .exec_error_code(ecode), .sweep_done(ev[2]),
        .plot_done(ev[3]), .breaker_changed(ev[4]), .interlock_changed(ev[5]),
        .general_request_enable_write(wr[0]), .completion_request_enable_write(wr[1]),
        .enable_value(enable_value), .general_request_enable_query(qry[0]),
        .completion_request_enable_query(qry[1]), .enable_reply(enable_reply),
        .enable_reply_valid(enable_reply_valid), .poll_req(poll_req), .poll_ack(poll_ack),
        .status_byte(status_byte), .event_query(event_query), .event_ack(event_ack),
        .event_code_out(event_code_out), .srq(srq));
    gpib_controller_model u_gpib_controller_model (.clock(clock), .poll_ack(poll_ack),
        .status_byte(status_byte), .event_ack(event_ack), .event_code_out(event_code_out),
        .poll_req(poll_req), .event_query(event_query));
    // Clock
    initial forever #12.5 clock = ~clock;
    // Hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    function automatic bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Model request line
    function automatic logic msrq();
        return (pv != 0) && ((po != 0) ? (completion_request_enable != 0) : (gen != 0));
    endfunction : msrq
    // Model: keep pending and latest, newest first, drop oldest
    task post(int st, int o, int cd);
        if (pv == 0) begin
            pv = 1; ps = st; po = o;
        end else begin
            lv = 1; ls = st; lo = o;
        end
        codes.push_front(cd);
        if (codes.size() > 10) codes.pop_back();
    endtask : post
    // Drive one event pulse and check the request line
    task send(int k, int cd);
        @(posedge clock) ev[k] <= 1'b1;
        ecode <= cd[9:0];
        @(posedge clock) ev[k] <= 1'b0;
        post(k == 0 ? 97 : k == 1 ? 98 : 192, k > 1, k > 1 ? 750 + k : cd);
        #1 `CHK(srq, msrq())
    endtask : send
    // Poll and compare; release, reassert
    task chk_poll();
        int e;
        u_gpib_controller_model.poll(s);
        e = msrq() ? ps : 0;
        if (msrq()) begin
            pv = lv; ps = ls; po = lo; lv = 0;
        end
        `CHK(s, e)
        #1 `CHK(srq, msrq())
    endtask : chk_poll
    // Query and compare; zero when empty
    task chk_query();
        int e;
        u_gpib_controller_model.query(c);
        e = codes.size() ? codes.pop_front() : 0;
        `CHK(c, e)
    endtask : chk_query
    // Enable write
    task en(int w, bit v);
        @(posedge clock) wr[w] <= 1'b1;
        enable_value <= v;
        @(posedge clock) wr[w] <= 1'b0;
        if (w == 0) gen = v; else completion_request_enable = v;
        #1 `CHK(srq, msrq())
    endtask : en
    // Enable query; on or off only
    task enq(int w);
        @(posedge clock) qry[w] <= 1'b1;
        @(posedge clock) qry[w] <= 1'b0;
        repeat (4) begin
            @(posedge clock);
            if (enable_reply_valid === 1'b1) break;
        end
        `CHK(enable_reply, w == 0 ? gen[0] : completion_request_enable[0])
    endtask : enq
    task wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        post(65, 0, 401);
        #1 `CHK(srq, 1'b1)
        chk_poll();
        chk_query();
        enq(0);
        enq(1);
        $display("test power_on done");
        // Back to back errors overflow the store
        for (int i = 0; i < 12; i++) send(rnd() & 1, rnd() & 32'h3ff);
        repeat (3) chk_poll();
        repeat (11) chk_query();
        $display("test lifo done");
        en(0, 0);
        send(0, 106);
        en(0, 1);
        chk_poll();
        chk_query();
        $display("test general_mask done");
        send(2, 0);
        en(1, 1);
        enq(1);
        for (int k = 2; k < 6; k++) begin
            if (k > 2) send(k, 0);
            chk_poll();
            chk_query();
        end
        $display("test completion done");
        wrap_up();
    end
endmodule : test_gpib_service_request_reporter
